// *** hdl/urd_uart_regs.sv ***
// urd_uart_regs: bus slave decode of the uart register set, plus baud and receiver clock steering.
// assumes a single master that holds select until the transfer acknowledge is seen.
`timescale 1ns/10ps

// Summary of operation
// - bus write data and slave read data widths follow the data-width parameter.
// - address width follows address parameter; byte enables are that width over eight.
// - without external receiver clock, the receiver uses internal baud tick output.
// - registers sit at fixed offsets above a build-time base address.
// - line-control bit 7 acts as an extra address qualifier for some registers.
// - divisor bit clear, offset 0x1000 reads receive buffer, writes transmit holding.
// - divisor bit clear, offset 0x1004 is the interrupt enable register.
// - divisor bit clear, offset 0x1008 is the read-only interrupt identification.
// - line control read/write at 0x100C regardless of divisor bit.
// - modem control read/write at 0x1010 regardless of divisor bit.
// - line status decoded read/write at 0x1014 regardless of divisor bit.
// - modem status decoded read/write at 0x1018 regardless of divisor bit.
// - scratch register read/write at 0x101C regardless of divisor bit.
// - divisor bit set, offset 0x1000 is divisor low byte.
// - divisor bit set, offset 0x1004 is divisor high byte.
// - setting line-control bit 7 opens the divisor latches; clearing restores decode.
// - error acknowledge, retry and timeout suppress stay inactive always.
// - receiver clock runs at sixteen times the bit rate.
module urd_uart_regs #(
	parameter int          DataWidth    = urd_pkg::DATA_WIDTH, // bus data width
	parameter int          AddrWidth    = urd_pkg::ADDR_WIDTH, // bus address width
	parameter logic [31:0] BaseAddr     = urd_pkg::BASE_ADDR,  // register block base
	parameter bit          HasExtRefClk = 1'b0,                // reference from pin
	parameter bit          HasExtRxClk  = 1'b0                 // receiver clock from pin
) (
	input  wire logic                     clock,              // bus clock, 10 MHz
	input  wire logic                     reset,              // sync, active high
	input  wire logic [AddrWidth-1:0]     busAddr,            // address
	input  wire logic [AddrWidth/8-1:0]   busByteEn,          // byte enables
	input  wire logic [DataWidth-1:0]     busWriteData,       // write data
	input  wire logic                     busReadNotWrite,    // 1 read, 0 write
	input  wire logic                     busSelect,          // transfer request
	input  wire logic                     busSeqAddr,         // unused
	output logic      [DataWidth-1:0]     slaveReadData,      // read data, zero outside ack
	output logic                          slaveErrorAck,      // always low
	output logic                          slaveRetry,         // always low
	output logic                          slaveTimeoutSuppress, // always low
	output logic                          slaveTransferAck,   // one-cycle acknowledge
	input  wire logic                     refClockPin,        // external baud reference
	input  wire logic                     rxClockPin,         // external 16x receive clock
	output logic                          baudTickOutN,       // 16x baud, active low pulse
	output logic                          rxSampleTick,       // receiver 16x enable
	input  wire logic [7:0]               rxCharIn,           // character from receiver
	input  wire logic                     rxCharValid,        // receiver has a character
	output logic      [7:0]               txHoldingOut,       // character to send
	output logic                          txHoldingLoad,      // pulse on holding write
	output logic      [7:0]               lineControlOut,     // framing configuration
	output logic      [7:0]               modemControlOut     // modem control bits
);
	urd_pkg::urd_state_t stateQ;
	logic [7:0]  rxBufQ, thrQ, ierQ, lcrQ, mcrQ, lsrQ, msrQ, scrQ;
	logic [15:0] divisorQ, baudCntQ;
	logic [DataWidth-1:0] readDataQ;
	logic [AddrWidth-1:0] offset;
	logic        hit, divAccess, acc, rd, wr, wrLane0;
	logic [7:0]  wByte, readMux;
	logic        refSyncA, refSyncB, refPrevQ, refEdge;
	logic        rxSyncA, rxSyncB, rxPrevQ;
	logic        baudTick;

	// the base is a parameter, so the compare folds to constants per build
	assign offset    = busAddr - AddrWidth'(BaseAddr);
	assign hit       = busSelect && (offset < AddrWidth'(urd_pkg::OFS_SPAN))
	                   && (offset >= AddrWidth'(urd_pkg::OFS_DATA));
	assign divAccess = lcrQ[urd_pkg::DIV_ACCESS_BIT];
	assign acc       = hit && (stateQ == urd_pkg::ST_IDLE);
	assign rd        = acc && busReadNotWrite;
	assign wr        = acc && !busReadNotWrite;
	assign wrLane0   = wr && busByteEn[0];
	assign wByte     = busWriteData[7:0];

	assign slaveErrorAck        = 1'b0;
	assign slaveRetry           = 1'b0;
	assign slaveTimeoutSuppress = 1'b0;

	// acknowledge one cycle after select; the idle cycle keeps ack to one cycle, but a still-held select is acked again
	always_ff @(posedge clock) begin
		if (reset) begin
			stateQ <= urd_pkg::ST_IDLE;
		end else begin
			case (stateQ)
				urd_pkg::ST_IDLE: begin
					if (hit) begin
						stateQ <= urd_pkg::ST_ACK;
					end
				end
				urd_pkg::ST_ACK: begin
					stateQ <= urd_pkg::ST_IDLE;
				end
				default: begin
					stateQ <= urd_pkg::ST_IDLE;
				end
			endcase
		end
	end
	assign slaveTransferAck = (stateQ == urd_pkg::ST_ACK);

	always_comb begin
		readMux = 8'h00;
		if (offset == AddrWidth'(urd_pkg::OFS_DATA)) begin
			readMux = divAccess ? divisorQ[7:0] : rxBufQ;
		end else if (offset == AddrWidth'(urd_pkg::OFS_INT_ENABLE)) begin
			readMux = divAccess ? divisorQ[15:8] : ierQ;
		end else if (offset == AddrWidth'(urd_pkg::OFS_INT_IDENT)) begin
			readMux = divAccess ? 8'h00 : urd_pkg::RST_IIR;
		end else if (offset == AddrWidth'(urd_pkg::OFS_LINE_CONTROL)) begin
			readMux = lcrQ;
		end else if (offset == AddrWidth'(urd_pkg::OFS_MODEM_CONTROL)) begin
			readMux = mcrQ;
		end else if (offset == AddrWidth'(urd_pkg::OFS_LINE_STATUS)) begin
			readMux = lsrQ;
		end else if (offset == AddrWidth'(urd_pkg::OFS_MODEM_STATUS)) begin
			readMux = msrQ;
		end else if (offset == AddrWidth'(urd_pkg::OFS_SCRATCH)) begin
			readMux = scrQ;
		end
	end

	// read data is registered and only non-zero in the ack cycle, as the bus ors slaves
	always_ff @(posedge clock) begin
		if (reset) begin
			readDataQ <= '0;
		end else if (rd) begin
			readDataQ <= {{(DataWidth-8){1'b0}}, readMux};
		end else begin
			readDataQ <= '0;
		end
	end
	assign slaveReadData = readDataQ;

	always_ff @(posedge clock) begin
		if (reset) begin
			lcrQ <= urd_pkg::RST_ZERO;
			mcrQ <= urd_pkg::RST_ZERO;
			scrQ <= urd_pkg::RST_ZERO;
			msrQ <= urd_pkg::RST_ZERO;
		end else if (wrLane0) begin
			if (offset == AddrWidth'(urd_pkg::OFS_LINE_CONTROL)) begin
				lcrQ <= wByte;
			end else if (offset == AddrWidth'(urd_pkg::OFS_MODEM_CONTROL)) begin
				mcrQ <= wByte;
			end else if (offset == AddrWidth'(urd_pkg::OFS_MODEM_STATUS)) begin
				msrQ <= wByte;
			end else if (offset == AddrWidth'(urd_pkg::OFS_SCRATCH)) begin
				scrQ <= wByte;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			ierQ     <= urd_pkg::RST_ZERO;
			divisorQ <= urd_pkg::RST_DIVISOR;
			thrQ     <= urd_pkg::RST_THR;
		end else if (wrLane0) begin
			if (offset == AddrWidth'(urd_pkg::OFS_DATA)) begin
				if (divAccess) begin
					divisorQ[7:0] <= wByte;
				end else begin
					thrQ <= wByte;
				end
			end else if (offset == AddrWidth'(urd_pkg::OFS_INT_ENABLE)) begin
				if (divAccess) begin
					divisorQ[15:8] <= wByte;
				end else begin
					// upper enable bits are accepted but always read as zero
					ierQ <= {4'h0, wByte[urd_pkg::IER_USED_BITS-1:0]};
				end
			end
		end
	end
	assign txHoldingLoad  = wrLane0 && !divAccess
	                        && (offset == AddrWidth'(urd_pkg::OFS_DATA));
	assign txHoldingOut   = thrQ;
	assign lineControlOut = lcrQ;
	assign modemControlOut = mcrQ;

	// receive buffer and status: hardware set wins over a software write of the same bit
	always_ff @(posedge clock) begin
		if (reset) begin
			rxBufQ <= urd_pkg::RST_ZERO;
			lsrQ   <= urd_pkg::RST_LSR;
		end else begin
			if (wrLane0 && offset == AddrWidth'(urd_pkg::OFS_LINE_STATUS)) begin
				lsrQ <= wByte;
			end
			if (rd && !divAccess && offset == AddrWidth'(urd_pkg::OFS_DATA)) begin
				lsrQ[urd_pkg::LSR_DATA_READY_BIT] <= 1'b0;
			end
			if (rxCharValid) begin
				rxBufQ <= rxCharIn;
				lsrQ[urd_pkg::LSR_DATA_READY_BIT] <= 1'b1;
			end
		end
	end

	// reference clock: internal path counts bus cycles, pin path counts synced edges
	always_ff @(posedge clock) begin
		if (reset) begin
			refSyncA <= 1'b0;
			refSyncB <= 1'b0;
			refPrevQ <= 1'b0;
			rxSyncA  <= 1'b0;
			rxSyncB  <= 1'b0;
			rxPrevQ  <= 1'b0;
		end else begin
			refSyncA <= refClockPin;
			refSyncB <= refSyncA;
			refPrevQ <= refSyncB;
			rxSyncA  <= rxClockPin;
			rxSyncB  <= rxSyncA;
			rxPrevQ  <= rxSyncB;
		end
	end
	assign refEdge = HasExtRefClk ? (refSyncB && !refPrevQ) : 1'b1;

	// tick each divisor reference edges; a zero divisor stalls the generator
	always_ff @(posedge clock) begin
		if (reset) begin
			baudCntQ <= urd_pkg::RST_DIVISOR;
		end else if (refEdge) begin
			if (baudCntQ <= 16'h0001) begin
				baudCntQ <= divisorQ;
			end else begin
				baudCntQ <= baudCntQ - 16'h0001;
			end
		end
	end
	assign baudTick     = refEdge && (baudCntQ == 16'h0001) && (divisorQ != 16'h0000);
	assign baudTickOutN = !baudTick;
	// pin clock is only meaningful when far below the bus clock: a tick per synced edge
	assign rxSampleTick = HasExtRxClk ? (rxSyncB && !rxPrevQ) : baudTick;

	// assertions
	// reference edges since the last counter reload, an independent view of the divide ratio
	logic [15:0] refSinceLoadQ, loadedDivQ;
	logic        reloadSeenQ;
	always_ff @(posedge clock) begin
		if (reset) begin
			refSinceLoadQ <= 16'h0000;
			loadedDivQ    <= 16'h0000;
			reloadSeenQ   <= 1'b0;
		end else if (refEdge && baudCntQ <= 16'h0001) begin
			refSinceLoadQ <= 16'h0001;
			loadedDivQ    <= divisorQ;
			reloadSeenQ   <= 1'b1;
		end else if (refEdge) begin
			refSinceLoadQ <= refSinceLoadQ + 16'h0001;
		end
	end

	AST_ACK_ONE: assert property (@(posedge clock) disable iff (reset)
		slaveTransferAck |=> !slaveTransferAck)
		else $error("ack longer than one cycle");
	AST_ACK_FOLLOWS: assert property (@(posedge clock) disable iff (reset)
		(hit && !slaveTransferAck) |=> slaveTransferAck)
		else $error("addressed access not acknowledged");
	AST_ACK_TAKEN: assert property (@(posedge clock) disable iff (reset)
		slaveTransferAck |-> $past(hit))
		else $error("ack without an addressed access");
	AST_NO_ERR: assert property (@(posedge clock)
		!(slaveErrorAck || slaveRetry || slaveTimeoutSuppress))
		else $error("error outputs active");
	AST_SCRATCH: assert property (@(posedge clock) disable iff (reset)
		(wrLane0 && offset == AddrWidth'(urd_pkg::OFS_SCRATCH)) |=> scrQ == $past(wByte))
		else $error("scratch write not stored");
	AST_SCRATCH_RD: assert property (@(posedge clock) disable iff (reset)
		(rd && offset == AddrWidth'(urd_pkg::OFS_SCRATCH))
		|=> slaveReadData[7:0] == $past(scrQ))
		else $error("scratch readback wrong");
	AST_DLL_WR: assert property (@(posedge clock) disable iff (reset)
		(wrLane0 && divAccess && offset == AddrWidth'(urd_pkg::OFS_DATA))
		|=> divisorQ[7:0] == $past(wByte) && thrQ == $past(thrQ))
		else $error("divisor low write wrong");
	AST_DLM_WR: assert property (@(posedge clock) disable iff (reset)
		(wrLane0 && divAccess && offset == AddrWidth'(urd_pkg::OFS_INT_ENABLE))
		|=> divisorQ[15:8] == $past(wByte) && ierQ == $past(ierQ))
		else $error("divisor high write wrong");
	AST_DLL_RD: assert property (@(posedge clock) disable iff (reset)
		(rd && divAccess && offset == AddrWidth'(urd_pkg::OFS_DATA))
		|=> slaveReadData[7:0] == divisorQ[7:0])
		else $error("divisor low read wrong");
	AST_THR_WR: assert property (@(posedge clock) disable iff (reset)
		(wrLane0 && !divAccess && offset == AddrWidth'(urd_pkg::OFS_DATA))
		|=> thrQ == $past(wByte) && divisorQ == $past(divisorQ))
		else $error("holding write wrong");
	AST_RBR_RD: assert property (@(posedge clock) disable iff (reset)
		(rd && !divAccess && offset == AddrWidth'(urd_pkg::OFS_DATA))
		|=> slaveReadData[7:0] == $past(rxBufQ))
		else $error("receive buffer read wrong");
	AST_RX_SET: assert property (@(posedge clock) disable iff (reset)
		rxCharValid |=> lsrQ[urd_pkg::LSR_DATA_READY_BIT] && rxBufQ == $past(rxCharIn))
		else $error("received character not captured");
	AST_DLM_RD: assert property (@(posedge clock) disable iff (reset)
		(rd && divAccess && offset == AddrWidth'(urd_pkg::OFS_INT_ENABLE))
		|=> slaveReadData[7:0] == divisorQ[15:8])
		else $error("divisor high read wrong");
	AST_IER_RD: assert property (@(posedge clock) disable iff (reset)
		(rd && !divAccess && offset == AddrWidth'(urd_pkg::OFS_INT_ENABLE))
		|=> slaveReadData[7:0] == ierQ && ierQ[7:4] == 4'h0)
		else $error("interrupt enable read wrong");
	AST_IIR_RD: assert property (@(posedge clock) disable iff (reset)
		(rd && offset == AddrWidth'(urd_pkg::OFS_INT_IDENT))
		|=> slaveReadData[7:0] == (divAccess ? 8'h00 : urd_pkg::RST_IIR))
		else $error("interrupt identification read wrong");
	AST_LCR_WR: assert property (@(posedge clock) disable iff (reset)
		(wrLane0 && offset == AddrWidth'(urd_pkg::OFS_LINE_CONTROL))
		|=> lineControlOut == $past(wByte))
		else $error("line control write wrong");
	AST_MCR_WR: assert property (@(posedge clock) disable iff (reset)
		(wrLane0 && offset == AddrWidth'(urd_pkg::OFS_MODEM_CONTROL))
		|=> modemControlOut == $past(wByte))
		else $error("modem control write wrong");
	AST_LSR_WR: assert property (@(posedge clock) disable iff (reset)
		(wrLane0 && offset == AddrWidth'(urd_pkg::OFS_LINE_STATUS) && !rxCharValid)
		|=> lsrQ == $past(wByte))
		else $error("line status write wrong");
	AST_MSR_WR: assert property (@(posedge clock) disable iff (reset)
		(wrLane0 && offset == AddrWidth'(urd_pkg::OFS_MODEM_STATUS))
		|=> msrQ == $past(wByte))
		else $error("modem status write wrong");
	AST_LANE_GATE: assert property (@(posedge clock) disable iff (reset)
		(wr && !busByteEn[0]) |=> lcrQ == $past(lcrQ) && mcrQ == $past(mcrQ) && scrQ == $past(scrQ)
		&& msrQ == $past(msrQ) && ierQ == $past(ierQ) && divisorQ == $past(divisorQ))
		else $error("write without low lane stored");
	AST_UNMAPPED: assert property (@(posedge clock) disable iff (reset)
		(rd && (offset > AddrWidth'(urd_pkg::OFS_SCRATCH) || offset[1:0] != 2'b00))
		|=> slaveReadData == '0)
		else $error("unmapped read not zero");
	AST_IDLE_ZERO: assert property (@(posedge clock) disable iff (reset)
		!slaveTransferAck |-> slaveReadData == '0)
		else $error("read data outside ack");
	AST_BAUD_RATIO: assert property (@(posedge clock) disable iff (reset)
		(baudTick && reloadSeenQ) |-> refSinceLoadQ == loadedDivQ)
		else $error("baud tick spacing differs from divisor");

	// main scenarios
	COV_DIV_WRITE: cover property (@(posedge clock) disable iff (reset)
		wrLane0 && divAccess);
	COV_RX_READ: cover property (@(posedge clock) disable iff (reset)
		rd && !divAccess && offset == AddrWidth'(urd_pkg::OFS_DATA));
	COV_BAUD: cover property (@(posedge clock) disable iff (reset) baudTick);
	COV_UNMAPPED_RD: cover property (@(posedge clock) disable iff (reset)
		rd && offset > AddrWidth'(urd_pkg::OFS_SCRATCH));
	COV_LANE_DROP: cover property (@(posedge clock) disable iff (reset)
		wr && !busByteEn[0]);
endmodule

// *** pkg/urd_pkg.sv ***
// urd_pkg: register offsets, field positions and reset values of the uart register decode.
// assumes byte-wide registers, each on its own 32-bit aligned word, low byte of data.
package urd_pkg;
	localparam int DATA_WIDTH = 32;
	localparam int ADDR_WIDTH = 32;
	localparam logic [31:0] BASE_ADDR = 32'h8000_0000;
	localparam logic [15:0] OFS_DATA = 16'h1000;
	localparam logic [15:0] OFS_INT_ENABLE = 16'h1004;
	localparam logic [15:0] OFS_INT_IDENT = 16'h1008;
	localparam logic [15:0] OFS_LINE_CONTROL = 16'h100C;
	localparam logic [15:0] OFS_MODEM_CONTROL = 16'h1010;
	localparam logic [15:0] OFS_LINE_STATUS = 16'h1014;
	localparam logic [15:0] OFS_MODEM_STATUS = 16'h1018;
	localparam logic [15:0] OFS_SCRATCH = 16'h101C;
	localparam logic [15:0] OFS_SPAN = 16'h2000;
	localparam int DIV_ACCESS_BIT = 7;
	localparam int IER_USED_BITS = 4;
	localparam int LSR_THR_EMPTY_BIT = 5;
	localparam int LSR_TX_EMPTY_BIT = 6;
	localparam int LSR_DATA_READY_BIT = 0;
	localparam int RCLK_OVERSAMPLE = 16;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_THR = 8'hFF;
	localparam logic [7:0] RST_IIR = 8'h01;
	localparam logic [7:0] RST_LSR = 8'h60;
	localparam logic [15:0] RST_DIVISOR = 16'h0001;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_ACK  = 2'b10
	} urd_state_t;
endpackage

// *** dv/urd_bus_master.sv ***
// urd_bus_master: behavioural processor on the peripheral bus, one transfer at a time.
// assumes the slave acknowledges within eight cycles or not at all.
`timescale 1ns/10ps
module urd_bus_master (
	input  wire logic        clock,           // bus clock
	output logic      [31:0] busAddr,         // address
	output logic      [3:0]  busByteEn,       // byte enables
	output logic      [31:0] busWriteData,    // write data
	output logic             busReadNotWrite, // 1 read
	output logic             busSelect,       // request
	input  wire logic        ack,             // transfer acknowledge
	input  wire logic [31:0] readData         // read data
);
	logic [3:0] byteEn = 4'hF;
	initial begin
		busAddr = 32'h0;
		busByteEn = 4'h0;
		busWriteData = 32'h0;
		busReadNotWrite = 1'b1;
		busSelect = 1'b0;
	end
	// request held until ack is sampled high; a refused access just times out here
	task automatic xfer(input logic rnw, input logic [31:0] addr, input logic [7:0] wd,
			output logic [31:0] rd, output logic acked);
		acked = 1'b0;
		rd = 32'h0;
		@(negedge clock);
		busAddr = addr;
		busByteEn = byteEn;
		busWriteData = {24'hA5A5A5, wd};
		busReadNotWrite = rnw;
		busSelect = 1'b1;
		for (int i = 0; i < 8 && !acked; i++) begin
			@(posedge clock);
			if (ack === 1'b1) begin
				acked = 1'b1;
				rd = readData;
			end
		end
		@(negedge clock);
		busSelect = 1'b0;
		// released address, data and byte-enable lines show no stale value
		busAddr = ~addr;
		busWriteData = ~busWriteData;
		busByteEn = ~busByteEn;
	endtask
endmodule

// *** dv/urd_uart_regs_test.sv ***
// urd_uart_regs_test: self-checking bench for the uart register decode.
// assumes default build parameters and the master model urd_bus_master.
`timescale 1ns/10ps
module urd_uart_regs_test;
	localparam logic [31:0] Base = urd_pkg::BASE_ADDR;
	logic        clock = 1'b0;
	logic        reset = 1'b1;
	logic [31:0] busAddr, busWriteData, slaveReadData;
	logic [3:0]  busByteEn;
	logic        busReadNotWrite, busSelect, slaveTransferAck;
	logic        slaveErrorAck, slaveRetry, slaveTimeoutSuppress;
	logic        baudTickOutN, rxSampleTick, txHoldingLoad;
	logic        rxCharValid = 1'b0;
	logic [7:0]  rxCharIn = 8'h00;
	logic [7:0]  txHoldingOut, lineControlOut, modemControlOut;
	int          n_mismatch = 0;
	int          checked = 0;
	int          nLoads = 0;
	int          cycles = 0;

	urd_uart_regs i_dut (.clock(clock), .reset(reset), .busAddr(busAddr),
		.busByteEn(busByteEn), .busWriteData(busWriteData),
		.busReadNotWrite(busReadNotWrite), .busSelect(busSelect), .busSeqAddr(1'b0),
		.slaveReadData(slaveReadData), .slaveErrorAck(slaveErrorAck),
		.slaveRetry(slaveRetry), .slaveTimeoutSuppress(slaveTimeoutSuppress),
		.slaveTransferAck(slaveTransferAck), .refClockPin(1'b0), .rxClockPin(1'b0),
		.baudTickOutN(baudTickOutN), .rxSampleTick(rxSampleTick), .rxCharIn(rxCharIn),
		.rxCharValid(rxCharValid), .txHoldingOut(txHoldingOut),
		.txHoldingLoad(txHoldingLoad), .lineControlOut(lineControlOut),
		.modemControlOut(modemControlOut));
	urd_bus_master i_master (.clock(clock), .busAddr(busAddr), .busByteEn(busByteEn),
		.busWriteData(busWriteData), .busReadNotWrite(busReadNotWrite),
		.busSelect(busSelect), .ack(slaveTransferAck), .readData(slaveReadData));

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic acc(input logic rnw, input logic [15:0] ofs, input logic [7:0] wd,
			input logic [7:0] exp, input string name);
		logic [31:0] rd;
		logic        ok;
		i_master.xfer(rnw, Base + {16'h0, ofs}, wd, rd, ok);
		chk({name, " ack"}, 32'h1, {31'h0, ok});
		if (rnw)
			chk(name, {24'h0, exp}, rd);
	endtask
	task automatic wr_reg(input logic [15:0] ofs, input logic [7:0] wd);
		acc(1'b0, ofs, wd, 8'h00, "write");
	endtask
	task automatic rd_reg(input logic [15:0] ofs, input logic [7:0] exp, input string name);
		acc(1'b1, ofs, 8'h00, exp, name);
	endtask

	always @(posedge clock) begin
		cycles++;
		if (txHoldingLoad === 1'b1)
			nLoads++;
		if ({slaveErrorAck, slaveRetry, slaveTimeoutSuppress} !== 3'b000)
			chk("error outputs", 32'h0, {29'h0, slaveErrorAck, slaveRetry, slaveTimeoutSuppress});
		if (cycles == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	task automatic test_reset();
		rd_reg(16'h1000, 8'h00, "rx buffer reset");
		rd_reg(16'h1004, 8'h00, "int enable");
		rd_reg(16'h1008, 8'h01, "int ident");
		rd_reg(16'h100C, 8'h00, "line control");
		rd_reg(16'h1010, 8'h00, "modem control");
		rd_reg(16'h1014, 8'h60, "line status");
		rd_reg(16'h1018, 8'h00, "modem status");
		rd_reg(16'h101C, 8'h00, "scratch");
		chk("tx holding", 32'hFF, {24'h0, txHoldingOut});
	endtask
	task automatic test_regs();
		wr_reg(16'h1004, 8'hA5);
		rd_reg(16'h1004, 8'h05, "int enable");
		wr_reg(16'h1008, 8'hFF);
		rd_reg(16'h1008, 8'h01, "int ident");
		wr_reg(16'h100C, 8'h1B);
		rd_reg(16'h100C, 8'h1B, "line control");
		chk("line control out", 32'h1B, {24'h0, lineControlOut});
		wr_reg(16'h1010, 8'h1F);
		rd_reg(16'h1010, 8'h1F, "modem control");
		chk("modem control out", 32'h1F, {24'h0, modemControlOut});
		wr_reg(16'h1014, 8'h20);
		rd_reg(16'h1014, 8'h20, "line status");
		wr_reg(16'h1018, 8'hC4);
		rd_reg(16'h1018, 8'hC4, "modem status");
		wr_reg(16'h101C, 8'hA5);
		rd_reg(16'h101C, 8'hA5, "scratch");
	endtask
	task automatic test_divisor();
		wr_reg(16'h100C, 8'h9B);
		wr_reg(16'h1000, 8'h34);
		wr_reg(16'h1004, 8'h12);
		rd_reg(16'h1000, 8'h34, "divisor low");
		rd_reg(16'h1004, 8'h12, "divisor high");
		rd_reg(16'h1008, 8'h00, "ident with divisor bit");
		rd_reg(16'h100C, 8'h9B, "line control divisor bit");
		rd_reg(16'h101C, 8'hA5, "scratch");
		chk("tx untouched", 32'hFF, {24'h0, txHoldingOut});
		chk("no tx loads", 32'h0, nLoads);
		wr_reg(16'h100C, 8'h1B);
		rd_reg(16'h1004, 8'h05, "int enable");
		rd_reg(16'h1008, 8'h01, "int ident");
	endtask
	task automatic test_data();
		logic [31:0] rd;
		logic        ok;
		@(negedge clock);
		rxCharIn = 8'h7E;
		rxCharValid = 1'b1;
		@(negedge clock);
		rxCharValid = 1'b0;
		rxCharIn = 8'h81;
		rd_reg(16'h1014, 8'h21, "line status rx");
		rd_reg(16'h1000, 8'h7E, "rx buffer");
		wr_reg(16'h1000, 8'hC3);
		chk("tx holding", 32'hC3, {24'h0, txHoldingOut});
		chk("tx loads", 32'h1, nLoads);
		rd_reg(16'h1020, 8'h00, "unmapped");
		wr_reg(16'h1FFC, 8'h55);
		i_master.xfer(1'b1, Base + 32'h0FFC, 8'h00, rd, ok);
		chk("outside ack", 32'h0, {31'h0, ok});
		i_master.byteEn = 4'h0;
		wr_reg(16'h101C, 8'h3C);
		i_master.byteEn = 4'hF;
		rd_reg(16'h101C, 8'hA5, "scratch no lane");
	endtask
	task automatic test_baud();
		int nb;
		int nr;
		wr_reg(16'h100C, 8'h80);
		wr_reg(16'h1000, 8'h04);
		wr_reg(16'h1004, 8'h00);
		wr_reg(16'h100C, 8'h1B);
		nb = 0;
		nr = 0;
		// the counter may still be running out a large divisor loaded earlier
		for (int i = 0; i < 5000 && baudTickOutN !== 1'b0; i++)
			@(negedge clock);
		repeat (16) begin
			@(negedge clock);
			nb += (baudTickOutN === 1'b0);
			nr += (rxSampleTick === 1'b1);
		end
		chk("baud ticks", 32'h4, nb);
		chk("rx ticks", 32'h4, nr);
	endtask
	task automatic test_midreset();
		@(negedge clock);
		reset = 1'b1;
		repeat (10) @(negedge clock);
		reset = 1'b0;
		test_reset();
		wr_reg(16'h100C, 8'h80);
		rd_reg(16'h1000, 8'h01, "divisor low reset");
		rd_reg(16'h1004, 8'h00, "divisor high reset");
		wr_reg(16'h100C, 8'h00);
	endtask

	initial begin
		forever #50 clock = ~clock;
	end
	initial begin
		repeat (10) @(posedge clock);
		@(negedge clock);
		reset = 1'b0;
		test_reset();
		test_regs();
		test_divisor();
		test_data();
		test_baud();
		test_midreset();
		complete_run();
	end
endmodule
